// *** rtl/pin_mux_pkg.sv ***
// Purpose: constants and carriers for the shared-pin function multiplexer
// Assumes: apb with 32-bit data, one aligned word per register
// Notes: offsets chosen for this block
package pin_mux_pkg;
  localparam logic [7:0] OFS_PA_HI = 8'h00;
  localparam logic [7:0] OFS_PB_LO = 8'h04;
  localparam logic [7:0] OFS_PB_HI = 8'h08;
  localparam logic [7:0] OFS_PC_LO = 8'h0C;
  localparam logic [7:0] OFS_PC_HI = 8'h10;
  localparam logic [7:0] OFS_PD_LO = 8'h14;
  localparam logic [7:0] OFS_IS0 = 8'h18;
  localparam logic [7:0] OFS_IS1 = 8'h1C;
  localparam logic [7:0] OFS_IS2 = 8'h20;
  localparam logic [7:0] OFS_RBC = 8'h24;
  localparam logic [7:0] OFS_PORT_A = 8'h28;
  localparam logic [7:0] OFS_PORT_B = 8'h2C;
  localparam logic [7:0] OFS_PORT_C = 8'h30;
  localparam logic [7:0] OFS_PORT_D = 8'h34;
  localparam logic [7:0] MASK_PA_HI = 8'hF3;
  localparam logic [7:0] MASK_PC_HI = 8'h0F;
  localparam logic [7:0] MASK_IS0_SMALL = 8'h21;
  localparam logic [7:0] MASK_IS0_LARGE = 8'h61;
  localparam logic [7:0] MASK_IS1 = 8'h01;
  localparam logic [7:0] MASK_IS2 = 8'h03;
  localparam logic [7:0] RESET_VAL = 8'h00;
  localparam logic [7:0] READBACK_KEY = 8'hCA;
  localparam logic [1:0] SEL_ALT = 2'h3;
  localparam logic [1:0] SEL_MID = 2'h2;
  localparam int BIT_T0_SRC = 5;
  localparam int BIT_T1_SRC = 6;
  localparam int BIT_STD_TIMER_CLOCK_IN_SRC = 0;
  localparam int BIT_CAP_SRC = 0;
  localparam int BIT_IRQ1_SRC = 1;
  localparam int BIT_IRQ0_SRC = 0;

  typedef struct packed {
    logic main_osc_pin_a;
    logic main_osc_pin_b;
    logic io_supply_in;
    logic adc_ref;
    logic [7:0] adc_chan;
    logic std_timer_out_inverted;
    logic timer0_out_inverted;
    logic timer1_out;
    logic timer1_out_inverted;
    logic spi_clk;
    logic spi_out;
    logic spi_in;
    logic spi_slave_select;
    logic slow_crystal_in;
    logic slow_crystal_out;
    logic [3:0] lcd_common;
  } route_s;

  typedef struct packed {
    logic timer0_clock_in;
    logic timer1_clock_in;
    logic std_timer_clock_in;
    logic std_timer_capture_in;
    logic ext_irq0;
    logic ext_irq1;
  } periph_in_s;
endpackage

// *** rtl/pin_function_mux_readback.sv ***
// Purpose: shared-pin function selection with port readback mode
// Assumes: pins and peripheral levels synchronous to pclk
// Notes: LARGE_VARIANT enables the second periodic-timer options
//
// Contract
// - pa_hi bits 7..6 equal 11 route A7 to oscillator pin b
// - pa_hi bits 5..4 route A6 to oscillator a; bits 1..0 make A4 supply
// - B0 field: 00/01 gpio, 10 analog 0, 11 converter reference
// - B3/B2/B1 fields 11 give analog 3/2/1, else gpio with timer clocks
// - B7 field 11 gives analog 7; reset control overrides it
// - B6 field 11 gives analog 6, else gpio with capture input
// - B5 field: gpio/irq1, 10 inverted std timer out, 11 analog 5
// - B4 field: gpio/irq0, 10 inverted timer0 out, 11 analog 4
// - C3 field 11 selects serial clock
// - C2 field 11 selects spi data out shared with async transmit
// - C1 field 11 selects spi in, i2c data, async receive
// - C0 field 11 selects slave select, else gpio with capture
// - pc_hi bits 3..2 give slow crystal in on C5, 1..0 out on C4
// - port D fields 11 give lcd commons; D3/D2 fields 10 give timer1 outputs on large
// - input select 0 bit 5 picks timer0 clock; bit 6 timer1 clock
// - input select 0 bit 0 picks std timer clock from A5 or B1
// - input select 1 bit 0 picks capture from B6 or C0
// - input select 2 bits pick irq1 A1/B5 and irq0 A3/B4
// - unimplemented select bits ignore writes and read zero
// - writing key byte to readback control sets readback mode
// - readback off: pins follow selected function only
// - readback on: port data reads return the pin levels
// - any other byte clears readback mode
// - readback on forces the selected analog channel path on
module pin_function_mux_readback #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] pin_a,
  input wire logic [7:0] pin_b,
  input wire logic [7:0] pin_c,
  input wire logic [7:0] pin_d,
  input wire logic [7:0] latch_a,
  input wire logic [7:0] latch_b,
  input wire logic [7:0] latch_c,
  input wire logic [7:0] latch_d,
  input wire logic reset_control_register,
  input wire logic [2:0] adc_chan_sel,
  output pin_mux_pkg::route_s route,
  output pin_mux_pkg::periph_in_s periph_in,
  output logic external_reset_in_en,
  output logic readback_mode_signal
);
  logic [7:0] pa_hi_r, pb_lo_r, pb_hi_r, pc_lo_r, pc_hi_r, pd_lo_r;
  logic [7:0] is0_r, is1_r, is2_r;
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r, rb_r, rst_en_r;
  pin_mux_pkg::route_s route_r, route_nxt;
  pin_mux_pkg::periph_in_s pin_r, pin_nxt;

  wire [7:0] is0_mask = LARGE_VARIANT ? pin_mux_pkg::MASK_IS0_LARGE
                                      : pin_mux_pkg::MASK_IS0_SMALL;
  wire setup = psel && !penable;
  // the write lands only at the edge that completes the access
  wire wr = psel && penable && pready_r && pwrite;
  wire [7:0] wd = pwdata[7:0];
  wire hit_pa = paddr == pin_mux_pkg::OFS_PA_HI;
  wire hit_pbl = paddr == pin_mux_pkg::OFS_PB_LO;
  wire hit_pbh = paddr == pin_mux_pkg::OFS_PB_HI;
  wire hit_pcl = paddr == pin_mux_pkg::OFS_PC_LO;
  wire hit_pch = paddr == pin_mux_pkg::OFS_PC_HI;
  wire hit_pd = paddr == pin_mux_pkg::OFS_PD_LO;
  wire hit_is0 = paddr == pin_mux_pkg::OFS_IS0;
  wire hit_is1 = paddr == pin_mux_pkg::OFS_IS1;
  wire hit_is2 = paddr == pin_mux_pkg::OFS_IS2;
  wire hit_rbc = paddr == pin_mux_pkg::OFS_RBC;
  wire hit_pta = paddr == pin_mux_pkg::OFS_PORT_A;
  wire hit_ptb = paddr == pin_mux_pkg::OFS_PORT_B;
  wire hit_ptc = paddr == pin_mux_pkg::OFS_PORT_C;
  wire hit_ptd = paddr == pin_mux_pkg::OFS_PORT_D;
  wire hit_any = hit_pa | hit_pbl | hit_pbh | hit_pcl | hit_pch | hit_pd | hit_is0
               | hit_is1 | hit_is2 | hit_rbc | hit_pta | hit_ptb | hit_ptc | hit_ptd;
  // port data read: latch normally, pin level in readback mode
  wire [7:0] port_a_rd = rb_r ? pin_a : latch_a;
  wire [7:0] port_b_rd = rb_r ? pin_b : latch_b;
  wire [7:0] port_c_rd = rb_r ? pin_c : latch_c;
  wire [7:0] port_d_rd = rb_r ? pin_d : latch_d;
  wire [7:0] rd_byte =
      hit_pa ? pa_hi_r : hit_pbl ? pb_lo_r : hit_pbh ? pb_hi_r :
      hit_pcl ? pc_lo_r : hit_pch ? pc_hi_r : hit_pd ? pd_lo_r :
      hit_is0 ? is0_r : hit_is1 ? is1_r : hit_is2 ? is2_r :
      hit_rbc ? {7'h00, rb_r} : hit_pta ? port_a_rd : hit_ptb ? port_b_rd :
      hit_ptc ? port_c_rd : hit_ptd ? port_d_rd : 8'h00;

  // no wait state: answer in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup && !hit_any;
      prdata_r <= (setup && !pwrite) ? {24'h000000, rd_byte} : 32'h0000_0000;
    end
  end

  // writes land with pready, never in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_hi_r <= pin_mux_pkg::RESET_VAL;
      pb_lo_r <= pin_mux_pkg::RESET_VAL;
      pb_hi_r <= pin_mux_pkg::RESET_VAL;
      pc_lo_r <= pin_mux_pkg::RESET_VAL;
      pc_hi_r <= pin_mux_pkg::RESET_VAL;
      pd_lo_r <= pin_mux_pkg::RESET_VAL;
      is0_r <= pin_mux_pkg::RESET_VAL;
      is1_r <= pin_mux_pkg::RESET_VAL;
      is2_r <= pin_mux_pkg::RESET_VAL;
      rb_r <= 1'b0;
    end else if (wr) begin
      if (hit_pa) pa_hi_r <= wd & pin_mux_pkg::MASK_PA_HI;
      if (hit_pbl) pb_lo_r <= wd;
      if (hit_pbh) pb_hi_r <= wd;
      if (hit_pcl) pc_lo_r <= wd;
      if (hit_pch) pc_hi_r <= wd & pin_mux_pkg::MASK_PC_HI;
      if (hit_pd) pd_lo_r <= wd;
      if (hit_is0) is0_r <= wd & is0_mask;
      if (hit_is1) is1_r <= wd & pin_mux_pkg::MASK_IS1;
      if (hit_is2) is2_r <= wd & pin_mux_pkg::MASK_IS2;
      if (hit_rbc) rb_r <= (wd == pin_mux_pkg::READBACK_KEY);
    end
  end

  function automatic logic alt(input logic [1:0] f);
    alt = f == pin_mux_pkg::SEL_ALT;
  endfunction
  function automatic logic mid(input logic [1:0] f);
    mid = f == pin_mux_pkg::SEL_MID;
  endfunction

  // analog path per channel: selected function, or forced in readback mode
  logic [7:0] an_sel;
  assign an_sel = {alt(pb_hi_r[7:6]), alt(pb_hi_r[5:4]), alt(pb_hi_r[3:2]),
                   alt(pb_hi_r[1:0]), alt(pb_lo_r[7:6]), alt(pb_lo_r[5:4]),
                   alt(pb_lo_r[3:2]), mid(pb_lo_r[1:0])};
  wire [7:0] an_force = rb_r ? (8'h01 << adc_chan_sel) : 8'h00;

  always_comb begin
    route_nxt = '0;
    route_nxt.main_osc_pin_b = alt(pa_hi_r[7:6]);
    route_nxt.main_osc_pin_a = alt(pa_hi_r[5:4]);
    route_nxt.io_supply_in = alt(pa_hi_r[1:0]);
    route_nxt.adc_ref = alt(pb_lo_r[1:0]);
    // reset pin function wins over a selected analog 7; the readback force on channel 7 still wins
    route_nxt.adc_chan = (an_sel & ~{reset_control_register, 7'h00}) | an_force;
    route_nxt.std_timer_out_inverted = mid(pb_hi_r[3:2]);
    route_nxt.timer0_out_inverted = mid(pb_hi_r[1:0]);
    route_nxt.spi_clk = alt(pc_lo_r[7:6]);
    route_nxt.spi_out = alt(pc_lo_r[5:4]);
    route_nxt.spi_in = alt(pc_lo_r[3:2]);
    route_nxt.spi_slave_select = alt(pc_lo_r[1:0]);
    route_nxt.slow_crystal_in = alt(pc_hi_r[3:2]);
    route_nxt.slow_crystal_out = alt(pc_hi_r[1:0]);
    route_nxt.lcd_common = {alt(pd_lo_r[7:6]), alt(pd_lo_r[5:4]),
                            alt(pd_lo_r[3:2]), alt(pd_lo_r[1:0])};
    route_nxt.timer1_out_inverted = LARGE_VARIANT && mid(pd_lo_r[7:6]);
    route_nxt.timer1_out = LARGE_VARIANT && mid(pd_lo_r[5:4]);
  end

  // input routing; a pin whose field selects analog feeds nothing digital
  always_comb begin
    pin_nxt = '0;
    pin_nxt.timer0_clock_in = is0_r[pin_mux_pkg::BIT_T0_SRC] ?
        (pin_b[2] && !alt(pb_lo_r[5:4])) : (pin_a[4] && !alt(pa_hi_r[1:0]));
    pin_nxt.timer1_clock_in = LARGE_VARIANT && (is0_r[pin_mux_pkg::BIT_T1_SRC] ?
        (pin_b[3] && !alt(pb_lo_r[7:6])) : (pin_d[0] && !alt(pd_lo_r[1:0])));
    pin_nxt.std_timer_clock_in = is0_r[pin_mux_pkg::BIT_STD_TIMER_CLOCK_IN_SRC] ?
        (pin_b[1] && !alt(pb_lo_r[3:2])) : pin_a[5];
    pin_nxt.std_timer_capture_in = is1_r[pin_mux_pkg::BIT_CAP_SRC] ?
        (pin_c[0] && !alt(pc_lo_r[1:0])) : (pin_b[6] && !alt(pb_hi_r[5:4]));
    pin_nxt.ext_irq1 = is2_r[pin_mux_pkg::BIT_IRQ1_SRC] ?
        (pin_b[5] && !pb_hi_r[3]) : pin_a[1];
    pin_nxt.ext_irq0 = is2_r[pin_mux_pkg::BIT_IRQ0_SRC] ?
        (pin_b[4] && !pb_hi_r[1]) : pin_a[3];
  end

  // registered routing: one clean edge per change, no decode glitches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      route_r <= '0;
      pin_r <= '0;
      rst_en_r <= 1'b0;
    end else begin
      route_r <= route_nxt;
      pin_r <= pin_nxt;
      rst_en_r <= reset_control_register && !rb_r;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign route = route_r;
  assign periph_in = pin_r;
  assign external_reset_in_en = rst_en_r;
  assign readback_mode_signal = rb_r;
endmodule

// *** sim/pin_mux_far_model.sv ***
// Purpose: far side of the mux: pins, data latches, reset and channel requests
// Assumes: levels move one edge after a shuffle request
// Notes: random levels, so a stuck route shows up
module pin_mux_far_model (
  input wire logic pclk,
  input wire logic shuffle,
  output logic [7:0] pin_a,
  output logic [7:0] pin_b,
  output logic [7:0] pin_c,
  output logic [7:0] pin_d,
  output logic [7:0] latch_a,
  output logic [7:0] latch_b,
  output logic [7:0] latch_c,
  output logic [7:0] latch_d,
  output logic reset_control_register,
  output logic [2:0] adc_chan_sel
);
  timeunit 1ns;
  timeprecision 1ns;
  int seed = 7587;
  // one process drives every output, so each has a single driver
  initial begin
    {pin_d, pin_c, pin_b, pin_a} = 32'h0;
    {latch_d, latch_c, latch_b, latch_a} = 32'h0;
    {reset_control_register, adc_chan_sel} = 4'h0;
    forever begin
      @(posedge pclk);
      if (shuffle) begin
        {pin_d, pin_c, pin_b, pin_a} <= $random(seed);
        {latch_d, latch_c, latch_b, latch_a} <= $random(seed);
        {reset_control_register, adc_chan_sel} <= 4'($random(seed));
      end
    end
  end
endmodule

// *** sim/pin_function_mux_readback_chk.sv ***
// Purpose: port-level assertions for the shared-pin multiplexer
// Assumes: apb answer one cycle after setup, outputs registered
// Notes: bound to the top module
module pin_function_mux_readback_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic reset_control_register,
  input wire logic [2:0] adc_chan_sel,
  input wire pin_mux_pkg::route_s route,
  input wire logic external_reset_in_en,
  input wire logic readback_mode_signal
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire logic setup = psel && penable && pready && pwrite;
  wire logic rb_wr = setup && paddr == pin_mux_pkg::OFS_RBC;
  wire logic pd_wr = setup && paddr == pin_mux_pkg::OFS_PD_LO;
  wire logic key = pwdata[7:0] == pin_mux_pkg::READBACK_KEY;
  wire logic rst_on = reset_control_register && !readback_mode_signal;
  a_ready_next: assert property (psel && !penable |=> pready && penable)
    else $error("no ready in first access cycle");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_idle_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_key_sets: assert property (rb_wr && key |=> readback_mode_signal)
    else $error("key did not set readback");
  a_other_clears: assert property (rb_wr && !key |=> !readback_mode_signal)
    else $error("other byte did not clear readback");
  a_mode_steady: assert property (!rb_wr |=> $stable(readback_mode_signal))
    else $error("readback moved without write");
  a_reset_pin: assert property ($past(presetn) |-> external_reset_in_en == $past(rst_on))
    else $error("reset pin enable wrong");
  a_forced_adc: assert property ($past(presetn) && $past(readback_mode_signal)
    |-> route.adc_chan[$past(adc_chan_sel)])
    else $error("analog path not forced");
  a_lcd_write: assert property ($changed(route.lcd_common) |-> $past(pd_wr, 2))
    else $error("lcd route moved at wrong time");
  c_key: cover property (rb_wr && key);
  c_forced: cover property (readback_mode_signal && route.adc_chan != 8'h00);
  c_lcd: cover property ($changed(route.lcd_common));
endmodule
bind pin_function_mux_readback pin_function_mux_readback_chk i_chk (.*);

// *** sim/pin_function_mux_readback_test.sv ***
// Purpose: self-checking bench for the shared-pin multiplexer
// Assumes: large variant, one idle cycle between bus transfers
// Notes: model keeps its own register copy
module pin_function_mux_readback_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic shuffle = 1'b0;
  logic [31:0] prdata, r;
  logic pready, pslverr, e, reset_control_register;
  logic [7:0] pin_a, pin_b, pin_c, pin_d, latch_a, latch_b, latch_c, latch_d, v;
  logic [2:0] adc_chan_sel;
  logic readback_mode_signal, external_reset_in_en;
  logic [31:0] all_pin, all_latch;
  assign all_pin = {pin_d, pin_c, pin_b, pin_a};
  assign all_latch = {latch_d, latch_c, latch_b, latch_a};
  pin_mux_pkg::route_s route;
  pin_mux_pkg::periph_in_s periph_in;
  logic [7:0] cfg [9];
  logic [7:0] mask [9] = '{pin_mux_pkg::MASK_PA_HI, 8'hFF, 8'hFF, 8'hFF,
    pin_mux_pkg::MASK_PC_HI, 8'hFF, pin_mux_pkg::MASK_IS0_LARGE, pin_mux_pkg::MASK_IS1,
    pin_mux_pkg::MASK_IS2};
  logic mode = 1'b0;
  int error_cnt = 0;
  int compares = 0;
  int seed = 7587;
  int cycles = 0;
  always #25 pclk = ~pclk;
  pin_mux_far_model i_pin_mux_far_model (.*);
  pin_function_mux_readback i_pin_function_mux_readback (.*);
  function automatic logic q(int i, int l, int c);
    return 32'(cfg[i][l+:2]) == c;
  endfunction
  function automatic logic [31:0] exp_route();
    logic [7:0] adc;
    adc = {q(2, 6, 3) & !reset_control_register, q(2, 4, 3), q(2, 2, 3), q(2, 0, 3),
      q(1, 6, 3), q(1, 4, 3), q(1, 2, 3), q(1, 0, 2)};
    if (mode) adc[adc_chan_sel] = 1'b1;
    return {6'h0, q(0, 4, 3), q(0, 6, 3), q(0, 0, 3), q(1, 0, 3), adc, q(2, 2, 2), q(2, 0, 2),
      q(5, 4, 2), q(5, 6, 2), q(3, 6, 3), q(3, 4, 3), q(3, 2, 3), q(3, 0, 3), q(4, 2, 3),
      q(4, 0, 3), q(5, 6, 3), q(5, 4, 3), q(5, 2, 3), q(5, 0, 3)};
  endfunction
  function automatic logic [31:0] exp_in();
    return {26'h0, cfg[6][5] ? pin_b[2] & !q(1, 4, 3) : pin_a[4] & !q(0, 0, 3),
      cfg[6][6] ? pin_b[3] & !q(1, 6, 3) : pin_d[0] & !q(5, 0, 3),
      cfg[6][0] ? pin_b[1] & !q(1, 2, 3) : pin_a[5],
      cfg[7][0] ? pin_c[0] & !q(3, 0, 3) : pin_b[6] & !q(2, 4, 3),
      cfg[8][0] ? pin_b[4] & !cfg[2][1] : pin_a[3], cfg[8][1] ? pin_b[5] & !cfg[2][3] : pin_a[1]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wrap_up();
    $display("mismatches %0d, compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      wrap_up();
    end
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 10; i++) begin
      xfer(1'b0, 8'(4 * i), 32'h0);
      chk(r, 32'h0);
    end
    // first rounds walk 00/01/10/11 through every field
    for (int n = 0; n < 12; n++) begin
      for (int i = 0; i < 9; i++) begin
        v = n < 4 ? 8'(8'h55 * n) : 8'($random(seed));
        xfer(1'b1, 8'(4 * i), {24'($random(seed)), v});
        cfg[i] = v & mask[i];
      end
      v = n % 2 == 1 ? pin_mux_pkg::READBACK_KEY : 8'($random(seed));
      xfer(1'b1, pin_mux_pkg::OFS_RBC, {24'h0, v});
      mode = v == pin_mux_pkg::READBACK_KEY;
      chk({31'h0, readback_mode_signal}, {31'h0, mode});
      xfer(1'b1, 8'h38, 32'hFF);
      chk({31'h0, e}, 32'h1);
      shuffle <= 1'b1;
      @(posedge pclk);
      shuffle <= 1'b0;
      repeat (2) @(posedge pclk);
      chk(32'(route), exp_route());
      chk(32'(periph_in), exp_in());
      chk({31'h0, external_reset_in_en}, {31'h0, reset_control_register & !mode});
      for (int i = 0; i < 14; i++) begin
        xfer(1'b0, 8'(4 * i), 32'h0);
        v = i < 9 ? cfg[i] : i == 9 ? {7'h0, mode} : mode ? all_pin[8 * (i - 10)+:8]
          : all_latch[8 * (i - 10)+:8];
        chk(r, {24'h0, v});
      end
    end
    // second reset mid-run: selections and mode fall back to zero
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    mode = 1'b0;
    @(posedge pclk);
    chk(32'(route), 32'h0);
    chk({31'h0, readback_mode_signal}, 32'h0);
    for (int i = 0; i < 10; i++) begin
      xfer(1'b0, 8'(4 * i), 32'h0);
      chk(r, 32'h0);
    end
    wrap_up();
  end
endmodule
